// >>> hw/rsar_pkg.sv
// Functional notes
// R1: Range register reserved bits 31-7 and 5-4 always read zero.
// R2: Bit 6 is read-write, resets to 0; one turns internal reference off.
// R3: Range codes 0000-0100 select bipolar ranges of 3, 2.5, 1.5, 1.25, 0.625 Vref.
// R4: Range codes 1000-1011 select unipolar ranges of 3, 2.5, 1.5, 1.25 Vref.
// R5: Range field clears only on power-on reset; reference bit clears on app reset.
// R6: Range register bytes answer at addresses 14h, 15h, 16h and 17h.
// R7: Alarm status at 20h holds active and tripped high/low flags for input and supply.
// R8: Alarm status bits read-only, reset zero, at positions 15,14,11,10,7,6,5,4,0.
// R9: Alarm status bytes at 20h to 23h; upper half reads zero.
// R10: Overall alarm bit equals OR of the four tripped flags.
// R11: Writes to reserved bits or the alarm status change nothing.
package rsar_pkg;

    // ********************************************************
    // Register map.
    // ********************************************************
    localparam logic [7:0] RANGE_CFG_ADDR = 8'h14;
    localparam logic [7:0] ALARM_STAT_ADDR = 8'h20;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h30;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h34;

    // ********************************************************
    // Field positions.
    // ********************************************************
    localparam int REF_OFF_BIT = 6;
    localparam int ACT_SUP_LOW_BIT = 15;
    localparam int ACT_SUP_HIGH_BIT = 14;
    localparam int ACT_IN_LOW_BIT = 11;
    localparam int ACT_IN_HIGH_BIT = 10;
    localparam int TRP_SUP_LOW_BIT = 7;
    localparam int TRP_SUP_HIGH_BIT = 6;
    localparam int TRP_IN_LOW_BIT = 5;
    localparam int TRP_IN_HIGH_BIT = 4;
    localparam int ANY_ALARM_BIT = 0;

    // ********************************************************
    // Reset values and range codes.
    // ********************************************************
    localparam logic [3:0] RANGE_RESET = 4'h0;
    localparam logic REF_OFF_RESET = 1'b0;
    localparam logic [15:0] ALARM_RESET = 16'h0000;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [3:0] BIPOLAR_LAST = 4'h4;
    localparam logic [3:0] UNIPOLAR_FIRST = 4'h8;
    localparam logic [3:0] UNIPOLAR_LAST = 4'hb;
    localparam logic [7:0] IRQ_BITS = 8'hf0;

endpackage : rsar_pkg

// >>> hw/rsar_regs.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module rsar_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic app_reset,
    input wire logic active_supply_low,
    input wire logic active_supply_high,
    input wire logic active_input_low,
    input wire logic active_input_high,
    input wire logic latched_supply_low,
    input wire logic latched_supply_high,
    input wire logic latched_input_low,
    input wire logic latched_input_high,
    output logic [3:0] range_sel,
    output logic internal_ref_off,
    output logic any_latched_alarm,
    output logic irq
);

    // ********************************************************
    // Decoding helpers.
    // ********************************************************

    // Only the nine documented codes are accepted by the range field.
    function automatic logic range_code_ok(input logic [3:0] code);
        range_code_ok = (code <= rsar_pkg::BIPOLAR_LAST) ||
            (code >= rsar_pkg::UNIPOLAR_FIRST &&
             code <= rsar_pkg::UNIPOLAR_LAST);
    endfunction : range_code_ok

    // Word-aligned address match; the low two bits are ignored.
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] base);
        addr_hit = (a[7:2] == base[7:2]);
    endfunction : addr_hit

    logic [15:0] alarm_status;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [15:0] next_alarm_status;
    logic [7:0] next_irq_status;
    logic [7:0] next_irq_mask;
    logic [3:0] next_range_sel;
    logic next_ref_off;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic next_irq;
    logic wr_done;
    logic mapped;
    logic [7:0] trip_events;

    // ********************************************************
    // Bus slave.
    // ********************************************************

    // A write lands only at the edge where pready is sampled high.
    assign wr_done = psel && penable && pready && pwrite;
    assign mapped = addr_hit(paddr, rsar_pkg::RANGE_CFG_ADDR) ||
        addr_hit(paddr, rsar_pkg::ALARM_STAT_ADDR) ||
        addr_hit(paddr, rsar_pkg::IRQ_STAT_ADDR) ||
        addr_hit(paddr, rsar_pkg::IRQ_MASK_ADDR);

    // Answer one cycle into the access phase; the reply is registered.
    always_comb begin
        next_pready = psel && penable && !pready;
        next_pslverr = next_pready && !mapped;
        next_prdata = prdata;
        if (next_pready && !pwrite) begin
            next_prdata = 32'h0000_0000;
            // R1 reserved bits zero
            if (addr_hit(paddr, rsar_pkg::RANGE_CFG_ADDR)) begin
                next_prdata[3:0] = range_sel;
                next_prdata[rsar_pkg::REF_OFF_BIT] = internal_ref_off;
            end
            // R9 upper half zero
            if (addr_hit(paddr, rsar_pkg::ALARM_STAT_ADDR)) begin
                next_prdata[15:0] = alarm_status;
            end
            if (addr_hit(paddr, rsar_pkg::IRQ_STAT_ADDR)) begin
                next_prdata[7:0] = irq_status;
            end
            if (addr_hit(paddr, rsar_pkg::IRQ_MASK_ADDR)) begin
                next_prdata[7:0] = irq_mask;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // ********************************************************
    // Range configuration.
    // ********************************************************

    // All configuration bits live in byte lane 0, so only pstrb[0] counts.
    always_comb begin
        next_range_sel = range_sel;
        next_ref_off = internal_ref_off;
        // R6 byte lane decode
        if (wr_done && pstrb[0] &&
            addr_hit(paddr, rsar_pkg::RANGE_CFG_ADDR)) begin
            // R2 reference disable
            next_ref_off = pwdata[rsar_pkg::REF_OFF_BIT];
            // R3 bipolar codes
            // R4 unipolar codes
            if (range_code_ok(pwdata[3:0])) begin
                next_range_sel = pwdata[3:0];
            end
        end
        // R5 app reset scope
        if (app_reset) begin
            next_ref_off = rsar_pkg::REF_OFF_RESET;
        end
    end

    // R5 power-on only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_sel <= rsar_pkg::RANGE_RESET;
            internal_ref_off <= rsar_pkg::REF_OFF_RESET;
        end else begin
            range_sel <= next_range_sel;
            internal_ref_off <= next_ref_off;
        end
    end

    // ********************************************************
    // Alarm status and interrupts.
    // ********************************************************

    // Flags mirror the comparison logic; bus writes never reach them.
    always_comb begin
        next_alarm_status = rsar_pkg::ALARM_RESET;
        // R7 flag capture
        // R8 flag positions
        next_alarm_status[rsar_pkg::ACT_SUP_LOW_BIT] = active_supply_low;
        next_alarm_status[rsar_pkg::ACT_SUP_HIGH_BIT] = active_supply_high;
        next_alarm_status[rsar_pkg::ACT_IN_LOW_BIT] = active_input_low;
        next_alarm_status[rsar_pkg::ACT_IN_HIGH_BIT] = active_input_high;
        next_alarm_status[rsar_pkg::TRP_SUP_LOW_BIT] = latched_supply_low;
        next_alarm_status[rsar_pkg::TRP_SUP_HIGH_BIT] = latched_supply_high;
        next_alarm_status[rsar_pkg::TRP_IN_LOW_BIT] = latched_input_low;
        next_alarm_status[rsar_pkg::TRP_IN_HIGH_BIT] = latched_input_high;
        // R10 overall alarm
        next_alarm_status[rsar_pkg::ANY_ALARM_BIT] = latched_supply_low ||
            latched_supply_high || latched_input_low || latched_input_high;
    end

    // A new tripped flag is an event; the set beats a same-cycle clear.
    assign trip_events = next_alarm_status[7:0] & ~alarm_status[7:0] &
        rsar_pkg::IRQ_BITS;

    always_comb begin
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        // R11 writes ignored
        if (wr_done && pstrb[0] &&
            addr_hit(paddr, rsar_pkg::IRQ_STAT_ADDR)) begin
            next_irq_status = irq_status & ~pwdata[7:0];
        end
        if (wr_done && pstrb[0] &&
            addr_hit(paddr, rsar_pkg::IRQ_MASK_ADDR)) begin
            next_irq_mask = pwdata[7:0] & rsar_pkg::IRQ_BITS;
        end
        next_irq_status = next_irq_status | trip_events;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_status <= rsar_pkg::ALARM_RESET;
            irq_status <= rsar_pkg::IRQ_RESET;
            irq_mask <= rsar_pkg::IRQ_RESET;
            any_latched_alarm <= 1'b0;
            irq <= 1'b0;
        end else begin
            alarm_status <= next_alarm_status;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            any_latched_alarm <= next_alarm_status[rsar_pkg::ANY_ALARM_BIT];
            irq <= next_irq;
        end
    end

    // ********************************************************
    // Checks.
    // ********************************************************

    sequence s_rd_range;
        psel && penable && !pwrite && !pready &&
            addr_hit(paddr, rsar_pkg::RANGE_CFG_ADDR);
    endsequence

    sequence s_wr_range;
        wr_done && pstrb[0] && addr_hit(paddr, rsar_pkg::RANGE_CFG_ADDR);
    endsequence

    a_range_reserved_zero: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        s_rd_range ##1 pready |-> prdata[31:7] == 25'h0 &&
            prdata[5:4] == 2'h0)
        else $error("range register reserved bit read nonzero");

    a_ref_off_write: assert property ( // R2
        @(posedge pclk) disable iff (!presetn)
        s_wr_range and !app_reset |=>
            internal_ref_off == $past(pwdata[rsar_pkg::REF_OFF_BIT]))
        else $error("reference disable bit not written");

    a_range_valid_write: assert property ( // R3
        @(posedge pclk) disable iff (!presetn)
        s_wr_range and range_code_ok(pwdata[3:0]) |=>
            range_sel == $past(pwdata[3:0]))
        else $error("valid range code not stored");

    a_range_code_legal: assert property ( // R4
        @(posedge pclk) disable iff (!presetn)
        range_code_ok(range_sel))
        else $error("range field holds an undefined code");

    a_app_reset_scope: assert property ( // R5
        @(posedge pclk) disable iff (!presetn)
        app_reset && !wr_done |=> !internal_ref_off && $stable(range_sel))
        else $error("application reset scope wrong");

    a_range_read_data: assert property ( // R6
        @(posedge pclk) disable iff (!presetn)
        s_rd_range ##1 pready |->
            prdata[3:0] == range_sel && !pslverr)
        else $error("range read data mismatch");

    a_status_read_data: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && !pready &&
            addr_hit(paddr, rsar_pkg::ALARM_STAT_ADDR) ##1 pready |->
            prdata == {16'h0, $past(alarm_status)})
        else $error("alarm status read data mismatch");

    a_flags_track_inputs: assert property ( // R8
        @(posedge pclk) disable iff (!presetn)
        ##1 alarm_status[rsar_pkg::TRP_SUP_LOW_BIT] ==
            $past(latched_supply_low) &&
            alarm_status[rsar_pkg::ACT_SUP_LOW_BIT] ==
            $past(active_supply_low))
        else $error("alarm flag does not follow its source");

    a_overall_is_or: assert property ( // R10
        @(posedge pclk) disable iff (!presetn)
        alarm_status[rsar_pkg::ANY_ALARM_BIT] == |alarm_status[7:4] &&
            any_latched_alarm == alarm_status[rsar_pkg::ANY_ALARM_BIT])
        else $error("overall alarm is not the OR of tripped flags");

    a_status_write_none: assert property ( // R11
        @(posedge pclk) disable iff (!presetn)
        wr_done && addr_hit(paddr, rsar_pkg::ALARM_STAT_ADDR) |=>
            $stable(range_sel) && $stable(irq_mask))
        else $error("write to alarm status changed state");

endmodule : rsar_regs

// >>> sim/rsar_host.sv
`timescale 1ns/10ps
// ********************************************************
// Host controller model, the APB master.
// ********************************************************
module rsar_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic hung
);
    // The bus is idle at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        hung = 1'b0;
    end

    // One transfer; the bounded wait flags a slave that never answers.
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [3:0] s,
            output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        hung <= (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : rsar_host

// >>> sim/test_range_select_alarm_status_regs.sv
`timescale 1ns/10ps
// ********************************************************
// Self-checking bench for the range and alarm registers.
// ********************************************************
module test_range_select_alarm_status_regs;
    logic pclk, presetn, app_reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, flags;
    logic [31:0] pwdata, prdata, r, d;
    logic [3:0] pstrb, range_sel, rng;
    logic internal_ref_off, any_latched_alarm, irq, rerr, refb;
    int errors = 0;
    int total_checks = 0;
    int seed;

    // Clock at 40 MHz.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    rsar_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung());

    rsar_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .app_reset(app_reset),
        .active_supply_low(flags[7]), .active_supply_high(flags[6]),
        .active_input_low(flags[5]), .active_input_high(flags[4]),
        .latched_supply_low(flags[3]), .latched_supply_high(flags[2]),
        .latched_input_low(flags[1]), .latched_input_high(flags[0]),
        .range_sel(range_sel), .internal_ref_off(internal_ref_off),
        .any_latched_alarm(any_latched_alarm), .irq(irq));

    // A slave that never answers ends the run.
    always @(posedge host.hung) begin
        errors++;
        conclude();
    end

    task automatic chk(input string n, input logic [31:0] e,
            input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] a,
            input logic [31:0] wd);
        host.xfer(w, a, wd, 4'hf, r, rerr);
    endtask : acc

    function automatic logic [31:0] exp_cfg(input logic [3:0] c,
            input logic f);
        return {25'h0, f, 2'b00, c};
    endfunction : exp_cfg

    // Status word: active flags high, tripped flags, then their OR.
    function automatic logic [31:0] exp_alarm(input logic [7:0] f);
        return {16'h0, f[7:6], 2'b00, f[5:4], 2'b00, f[3:0], 3'b000,
            |f[3:0]};
    endfunction : exp_alarm

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // Main sequence.
    initial begin
        presetn = 1'b0;
        app_reset = 1'b0;
        flags = 8'h00;
        seed = $urandom(45);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, 8'h14, 0);
        chk("cfg reset", 0, r);
        acc(1'b0, 8'h20, 0);
        chk("alarm reset", 0, r);
        acc(1'b0, 8'h40, 0);
        chk("unmapped error", 1, {31'h0, rerr});
        $display("test reset done");
        rng = 4'h0;
        // Every code, written and read through all four byte lanes.
        for (int i = 0; i < 16; i++) begin
            d = $urandom();
            d[3:0] = i[3:0];
            acc(1'b1, 8'h14 | {6'h0, i[1:0]}, d);
            if (i < 5 || (i > 7 && i < 12)) rng = i[3:0];
            refb = d[6];
            acc(1'b0, 8'h17 - {6'h0, i[1:0]}, 0);
            chk("cfg word", exp_cfg(rng, refb), r);
            chk("range_sel", {28'h0, rng}, {28'h0, range_sel});
            chk("ref off", {31'h0, refb}, {31'h0, internal_ref_off});
        end
        host.xfer(1'b1, 8'h14, 32'h0, 4'he, r, rerr);
        acc(1'b0, 8'h14, 0);
        chk("strobe off", exp_cfg(rng, refb), r);
        $display("test range codes done");
        acc(1'b1, 8'h14, 32'h49);
        @(posedge pclk) app_reset <= 1'b1;
        @(posedge pclk) app_reset <= 1'b0;
        acc(1'b0, 8'h14, 0);
        chk("app reset", exp_cfg(4'h9, 1'b0), r);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, 8'h14, 0);
        chk("power reset", 0, r);
        $display("test resets done");
        // Random flags, held steady across each read.
        for (int i = 0; i < 24; i++) begin
            @(posedge pclk) flags <= 8'($urandom());
            acc(1'b1, 8'h20, 32'hffffffff);
            acc(1'b0, 8'h20 | {6'h0, i[1:0]}, 0);
            chk("alarm word", exp_alarm(flags), r);
            chk("any alarm", {31'h0, |flags[3:0]},
                {31'h0, any_latched_alarm});
        end
        $display("test alarm flags done");
        @(posedge pclk) flags <= 8'h00;
        acc(1'b1, 8'h30, 32'hff);
        acc(1'b1, 8'h34, 32'hff);
        acc(1'b0, 8'h34, 0);
        chk("mask bits", 32'hf0, r);
        acc(1'b1, 8'h34, 32'h10);
        @(posedge pclk) flags <= 8'h01;
        acc(1'b0, 8'h30, 0);
        chk("irq status", 32'h10, r);
        chk("irq on", 1, {31'h0, irq});
        acc(1'b1, 8'h34, 32'h20);
        acc(1'b0, 8'h30, 0);
        chk("irq masked", 0, {31'h0, irq});
        acc(1'b1, 8'h30, 32'h10);
        acc(1'b0, 8'h30, 0);
        chk("irq cleared", 0, r);
        $display("test interrupt done");
        conclude();
    end
endmodule : test_range_select_alarm_status_regs
